/* hdl/lps_sequencer.sv */
// lps_sequencer: low-power state sequencer top.
// assumes request pins are asynchronous, active low; snoop strobes come
// on the bus clock; perf writes come from core-clock logic.
// Behaviour
// - snoop in halt or stop-grant enters snoop state
// - extended halt disabled uses plain halt snoop
// - extended snoop states keep low ratio and voltage
// - sleep request in stop-grant enters sleep, clocks off
// - sleep ignores snoops and interrupt latching
// - held reset in sleep resets directly
// - thermal query unavailable in all sleep states
// - deep sleep request in sleep enters deep sleep
// - fifteen microseconds pll settle before sleep again
// - deep sleep ignores snoops and interrupts
// - deeper request in deep sleep lowers voltage
// - deeper entry jumps voltage code about 100 mV
// - higher point: raise voltage stepwise, then frequency
// - lower point: frequency first, then voltage stepwise
// - reduced-power status only in deeper sleep
// - stop-clock request enters stop-grant, release returns
`timescale 1ns/100ps
`default_nettype none
module lps_sequencer
	import lps_pkg::*;
#(
	parameter int PLL_CYC = PLL_SETTLE_CYC,
	parameter int HOLD_CYC = RESET_HOLD_CYC,
	parameter int STEP_CYC = VID_STEP_CYC
) (
	input wire logic i_clk, // core clock, 125 MHz
	input wire logic i_sys_rst, // synchronous reset, active high
	input wire logic i_bclk, // bus clock, may stop in deep sleep
	input wire logic i_all_halted, // all cores halted
	input wire logic i_ext_halt_en, // extended halt enabled
	input wire logic i_ext_stopgrant_en, // extended stop-grant enabled
	input wire logic i_stop_clock_request_n, // pin, async
	input wire logic i_sleep_request_n, // pin, async
	input wire logic i_deep_sleep_request_n, // pin, async
	input wire logic i_deeper_voltage_request_n, // pin, async
	input wire logic i_bus_reset_n, // reset pin, async
	input wire logic i_snoop_start, // bus clock strobe
	input wire logic i_snoop_done, // bus clock strobe
	input wire logic i_perf_wr, // perf point write strobe
	input wire logic [VID_W-1:0] i_perf_vid, // requested code
	input wire logic [RATIO_W-1:0] i_perf_ratio, // requested ratio
	output logic [VID_W-1:0] o_voltage_id_code, // to regulator
	output logic [RATIO_W-1:0] o_core_ratio, // core to bus ratio
	output logic o_reduced_power_status_n, // low in deeper sleep
	output logic o_thermal_query_ready, // thermal query served
	output logic o_irq_latch_en, // interrupt inputs latched
	output logic o_core_clk_en, // internal clocks running
	output logic o_core_init, // one-cycle core reset pulse
	output logic o_snoop_respond, // bus clock domain snoop answer
	output logic [3:0] o_state // current state code
);
	localparam int PW = $clog2(PLL_CYC + 1);
	localparam int HW = $clog2(HOLD_CYC + 1);
	localparam int NPIN = 5;

	if (PLL_CYC < 1 || HOLD_CYC < 1) begin : g_bad_count
		$error("pll and reset hold counts must be positive");
	end

	function automatic logic in_sleep(input lps_state_t s);
		return s inside {ST_SLEEP, ST_DEEP, ST_DEEPER, ST_PLL_WAIT};
	endfunction : in_sleep

	function automatic logic in_ext(input lps_state_t s);
		return s inside {ST_XHALT, ST_XHALT_SNP, ST_XSG, ST_XSG_SNP};
	endfunction : in_ext

	lps_snoop_if snp ();

	logic [NPIN-1:0] pin_m_q;
	logic [NPIN-1:0] pin_q;
	logic busy_m_q;
	logic busy_q;
	logic stop_clock_request_n_a;
	logic slp_a;
	logic deep_sleep_request_n_a;
	logic deeper_voltage_request_n_a;
	logic reset_a;

	lps_state_t state_q;
	lps_state_t state_d;
	logic ret_halt_q;
	logic ext_sleep_q;
	logic [PW-1:0] pll_cnt_q;
	logic [HW-1:0] hold_cnt_q;
	logic reset_fire;
	logic init_q;

	logic [VID_W-1:0] sw_vid_q;
	logic [RATIO_W-1:0] sw_ratio_q;
	logic [RATIO_W-1:0] ratio_q;
	logic [VID_W-1:0] want_vid;
	logic [RATIO_W-1:0] want_ratio;
	logic [VID_W-1:0] vid_target;
	logic [VID_W-1:0] deeper_code;
	logic vid_done;
	logic low_point;

	// every pin goes through two flops before anything looks at it
	always_ff @(posedge i_clk) begin
		pin_m_q <= {i_bus_reset_n, i_deeper_voltage_request_n,
			i_deep_sleep_request_n, i_sleep_request_n,
			i_stop_clock_request_n};
		pin_q <= pin_m_q;
		busy_m_q <= snp.busy;
		busy_q <= busy_m_q;
	end

	assign stop_clock_request_n_a = !pin_q[0];
	assign slp_a = !pin_q[1];
	assign deep_sleep_request_n_a = !pin_q[2];
	assign deeper_voltage_request_n_a = !pin_q[3];
	assign reset_a = !pin_q[4];

	lps_snoop_link u_link (
		.i_bclk(i_bclk),
		.i_sys_rst(i_sys_rst),
		.i_snoop_start(i_snoop_start),
		.i_snoop_done(i_snoop_done),
		.o_snoop_respond(o_snoop_respond),
		.lk(snp.link)
	);

	// snoops are only taken outside the sleep family
	assign snp.allow = !in_sleep(state_q);

	// reset must stay asserted for the hold time before it counts
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !reset_a || !in_sleep(state_q)) begin
			hold_cnt_q <= '0;
		end else if (hold_cnt_q != HW'(HOLD_CYC)) begin
			hold_cnt_q <= hold_cnt_q + 1'b1;
		end
	end
	assign reset_fire = (hold_cnt_q == HW'(HOLD_CYC));

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_NORMAL: begin
				if (stop_clock_request_n_a) begin
					state_d = i_ext_stopgrant_en ? ST_XSG : ST_SG;
				end else if (i_all_halted) begin
					state_d = i_ext_halt_en ? ST_XHALT : ST_HALT;
				end
			end
			ST_HALT, ST_XHALT: begin
				if (busy_q) begin
					state_d = (state_q == ST_XHALT) ? ST_XHALT_SNP
						: ST_HALT_SNP;
				end else if (stop_clock_request_n_a) begin
					state_d = i_ext_stopgrant_en ? ST_XSG : ST_SG;
				end else if (!i_all_halted) begin
					state_d = ST_NORMAL;
				end
			end
			ST_SG, ST_XSG: begin
				if (slp_a) begin
					state_d = ST_SLEEP;
				end else if (busy_q) begin
					state_d = (state_q == ST_XSG) ? ST_XSG_SNP
						: ST_SG_SNP;
				end else if (!stop_clock_request_n_a) begin
					if (!ret_halt_q) begin
						state_d = ST_NORMAL;
					end else begin
						state_d = i_ext_halt_en ? ST_XHALT : ST_HALT;
					end
				end
			end
			ST_HALT_SNP: begin
				if (!busy_q) begin
					state_d = ST_HALT;
				end
			end
			ST_XHALT_SNP: begin
				if (!busy_q) begin
					state_d = ST_XHALT;
				end
			end
			ST_SG_SNP: begin
				if (!busy_q) begin
					state_d = ST_SG;
				end
			end
			ST_XSG_SNP: begin
				if (!busy_q) begin
					state_d = ST_XSG;
				end
			end
			ST_SLEEP: begin
				if (reset_fire) begin
					state_d = ST_NORMAL;
				end else if (deep_sleep_request_n_a) begin
					state_d = ST_DEEP;
				end else if (!slp_a && !reset_a) begin
					// partner drops sleep right after reset; reset must still win
					state_d = ext_sleep_q ? ST_XSG : ST_SG;
				end
			end
			ST_DEEP: begin
				if (reset_fire) begin
					state_d = ST_NORMAL;
				end else if (deeper_voltage_request_n_a) begin
					state_d = ST_DEEPER;
				end else if (!deep_sleep_request_n_a) begin
					state_d = ST_PLL_WAIT;
				end
			end
			ST_DEEPER: begin
				if (reset_fire) begin
					state_d = ST_NORMAL;
				end else if (!deeper_voltage_request_n_a) begin
					state_d = ST_DEEP;
				end
			end
			ST_PLL_WAIT: begin
				if (reset_fire) begin
					state_d = ST_NORMAL;
				end else if (pll_cnt_q == '0) begin
					state_d = ST_SLEEP;
				end
			end
			default: begin
				state_d = ST_NORMAL;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// remember where stop-grant was entered from and which flavour slept
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || state_d == ST_NORMAL) begin
			ret_halt_q <= 1'b0;
			ext_sleep_q <= 1'b0;
		end else begin
			if (state_q inside {ST_HALT, ST_XHALT}
				&& state_d inside {ST_SG, ST_XSG}) begin
				ret_halt_q <= 1'b1;
			end
			if (state_d == ST_SLEEP && state_q inside {ST_SG, ST_XSG}) begin
				ext_sleep_q <= (state_q == ST_XSG);
			end
		end
	end

	// counts the settle time down from deep sleep exit
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pll_cnt_q <= '0;
		end else if (state_q != ST_PLL_WAIT) begin
			pll_cnt_q <= PW'(PLL_CYC - 1);
		end else if (pll_cnt_q != '0) begin
			pll_cnt_q <= pll_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			init_q <= 1'b0;
		end else begin
			init_q <= in_sleep(state_q) && reset_fire;
		end
	end

	// software point, clamped so the top ratio is never passed
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sw_vid_q <= VID_RST;
			sw_ratio_q <= RATIO_RST;
		end else if (i_perf_wr) begin
			sw_vid_q <= i_perf_vid;
			sw_ratio_q <= (i_perf_ratio > MAX_RATIO) ? MAX_RATIO
				: i_perf_ratio;
		end
	end

	// extended states and a sleep entered from them hold the low point
	assign low_point = in_ext(state_q)
		|| (in_sleep(state_q) && ext_sleep_q);
	assign want_vid = low_point ? LOW_VID : sw_vid_q;
	assign want_ratio = low_point ? LOW_RATIO : sw_ratio_q;
	assign deeper_code = (want_vid > DEEPER_DROP_CODES)
		? want_vid - DEEPER_DROP_CODES : '0;

	// lowering: hold voltage until the ratio has come down first
	assign vid_target = (ratio_q > want_ratio) ? o_voltage_id_code
		: want_vid;

	// raising: ratio waits for the voltage to reach its target
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ratio_q <= RATIO_RST;
		end else if (want_ratio < ratio_q) begin
			ratio_q <= want_ratio;
		end else if (want_ratio > ratio_q && vid_done) begin
			ratio_q <= want_ratio;
		end
	end

	lps_vid_stepper #(
		.STEP_CYC(STEP_CYC)
	) u_vid (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_target(vid_target),
		.i_jump(state_q == ST_DEEPER),
		.i_jump_code(deeper_code),
		.o_vid(o_voltage_id_code),
		.o_done(vid_done)
	);

	assign o_core_ratio = ratio_q;
	assign o_reduced_power_status_n = (state_q != ST_DEEPER);
	assign o_thermal_query_ready = !in_sleep(state_q);
	assign o_irq_latch_en = !in_sleep(state_q);
	assign o_core_clk_en = !in_sleep(state_q);
	assign o_core_init = init_q;
	assign o_state = state_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_deep_exit;
		state_q == ST_DEEP && !deep_sleep_request_n_a && !deeper_voltage_request_n_a && !reset_fire;
	endsequence

	sequence s_pll_settled;
		state_q == ST_PLL_WAIT && pll_cnt_q == '0 && !reset_fire;
	endsequence

	AST_PSI_ONLY_DEEPER: assert property (
		!o_reduced_power_status_n |-> state_q == ST_DEEPER)
		else $error("reduced power status outside deeper sleep");

	AST_SLEEP_QUIET: assert property (
		in_sleep(state_q) |-> !o_thermal_query_ready && !o_irq_latch_en
			&& !snp.allow && !o_core_clk_en)
		else $error("thermal, interrupt or snoop active while asleep");

	AST_SLEEP_ENTRY: assert property (
		state_q inside {ST_SG, ST_XSG} && slp_a |=> state_q == ST_SLEEP)
		else $error("sleep request in stop-grant not honoured");

	AST_DEEP_ENTRY: assert property (
		state_q == ST_SLEEP && deep_sleep_request_n_a && !reset_fire |=> state_q == ST_DEEP)
		else $error("deep sleep request in sleep not honoured");

	AST_PLL_SETTLE: assert property (
		s_deep_exit ##1 state_q == ST_PLL_WAIT |-> pll_cnt_q == PW'(PLL_CYC - 1))
		else $error("settle count not loaded on deep sleep exit");

	AST_PLL_TO_SLEEP: assert property (
		state_q == ST_SLEEP && $past(state_q) == ST_PLL_WAIT
			|-> $past(pll_cnt_q) == '0)
		else $error("sleep re-entered before settle time");

	AST_SETTLED_SLEEP: assert property (
		s_pll_settled |=> state_q == ST_SLEEP)
		else $error("settled pll did not return to sleep");

	AST_DEEPER_JUMP: assert property (
		state_q == ST_DEEPER ##1 state_q == ST_DEEPER
			|-> o_voltage_id_code == deeper_code)
		else $error("deeper sleep code not reached in one jump");

	AST_RATIO_UP_AFTER_VID: assert property (
		ratio_q > $past(ratio_q) |-> $past(vid_done))
		else $error("ratio raised before voltage reached target");

	AST_VID_DOWN_AFTER_RATIO: assert property (
		o_voltage_id_code < $past(o_voltage_id_code) && !$past(state_q == ST_DEEPER)
			|-> $past(ratio_q) <= $past(want_ratio))
		else $error("voltage lowered before ratio came down");

	AST_SNOOP_RETURN: assert property (
		state_q inside {ST_SG_SNP, ST_HALT_SNP} && !busy_q
			|=> state_q inside {ST_SG, ST_HALT})
		else $error("snoop state did not return after service");

	AST_EXT_SNOOP_POINT: assert property (
		state_q inside {ST_XHALT_SNP, ST_XSG_SNP} ##1 state_q == $past(state_q)
			|-> want_ratio == LOW_RATIO && want_vid == LOW_VID)
		else $error("extended snoop left the low point");

	AST_STOPCLK: assert property (
		state_q == ST_NORMAL && stop_clock_request_n_a |=> state_q inside {ST_SG, ST_XSG})
		else $error("stop-clock request not honoured");

	AST_RESET_IN_SLEEP: assert property (
		in_sleep(state_q) && reset_fire |=> state_q == ST_NORMAL && o_core_init)
		else $error("held reset in sleep did not reset directly");

	AST_RESET_HOLDS_SLEEP: assert property (
		state_q == ST_SLEEP && reset_a |=> !(state_q inside {ST_SG, ST_XSG}))
		else $error("sleep left for stop-grant while reset was held");
endmodule : lps_sequencer
`default_nettype wire

/* hdl/lps_pkg.sv */
// lps_pkg: constants and types shared by the low-power sequencer files.
// assumes a 125 MHz core clock; all timing counts derive from it.
package lps_pkg;

	localparam int CLK_NS = 8;
	localparam int VID_W = 7;
	localparam int RATIO_W = 5;

	// pll settle after deep sleep exit is a least time, so round up
	localparam int PLL_SETTLE_NS = 15000;
	localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS + CLK_NS - 1) / CLK_NS;

	// dwell between single voltage-code steps
	localparam int VID_STEP_NS = 1000;
	localparam int VID_STEP_CYC = (VID_STEP_NS + CLK_NS - 1) / CLK_NS;

	// reset pin must be held this long in sleep before it acts
	localparam int RESET_HOLD_NS = 1000;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;

	// one code is 12.5 mV; the deeper jump is about 100 mV
	localparam int VID_STEP_UV = 12500;
	localparam int DEEPER_DROP_UV = 100000;
	localparam logic [VID_W-1:0] DEEPER_DROP_CODES =
		VID_W'(DEEPER_DROP_UV / VID_STEP_UV);

	localparam logic [VID_W-1:0] VID_RST = 7'h30;
	localparam logic [RATIO_W-1:0] RATIO_RST = 5'h0A;
	localparam logic [VID_W-1:0] LOW_VID = 7'h20;
	localparam logic [RATIO_W-1:0] LOW_RATIO = 5'h06;
	localparam logic [RATIO_W-1:0] MAX_RATIO = 5'h0C;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'h0,
		ST_SG = 4'h1,
		ST_SLEEP = 4'h3,
		ST_DEEP = 4'h2,
		ST_DEEPER = 4'h6,
		ST_PLL_WAIT = 4'h7,
		ST_XSG = 4'h5,
		ST_HALT = 4'h4,
		ST_XHALT = 4'hC,
		ST_HALT_SNP = 4'hD,
		ST_XHALT_SNP = 4'hE,
		ST_SG_SNP = 4'h9,
		ST_XSG_SNP = 4'hB
	} lps_state_t;

endpackage : lps_pkg

/* hdl/lps_snoop_if.sv */
// lps_snoop_if: levels between the core-clock sequencer and the bus-clock
// snoop logic. each side synchronises what it receives.
`timescale 1ns/100ps
`default_nettype none
interface lps_snoop_if;
	logic allow;
	logic busy;
	modport core (output allow, input busy);
	modport link (input allow, output busy);
endinterface : lps_snoop_if
`default_nettype wire

/* hdl/lps_snoop_link.sv */
// lps_snoop_link: bus-clock side snoop tracker.
// assumes snoop start/done strobes are synchronous to the bus clock,
// which may stop while the sequencer is in deep sleep.
`timescale 1ns/100ps
`default_nettype none
module lps_snoop_link (
	input wire logic i_bclk, // bus clock
	input wire logic i_sys_rst, // core-domain reset, resynchronised here
	input wire logic i_snoop_start, // snoop phase begins
	input wire logic i_snoop_done, // snoop serviced by any agent
	output logic o_snoop_respond, // device is answering a snoop
	lps_snoop_if.link lk // levels to and from the sequencer
);
	logic rst_m_q;
	logic rst_q;
	logic allow_m_q;
	logic allow_q;
	logic busy_q;

	// reset release is taken a couple of bus edges late, harmless here
	always_ff @(posedge i_bclk) begin
		rst_m_q <= i_sys_rst;
		rst_q <= rst_m_q;
	end

	always_ff @(posedge i_bclk) begin
		allow_m_q <= lk.allow;
		allow_q <= allow_m_q;
	end

	// a snoop that arrives while sleeping is not taken at all
	always_ff @(posedge i_bclk) begin
		if (rst_q) begin
			busy_q <= 1'b0;
		end else if (i_snoop_done) begin
			busy_q <= 1'b0;
		end else if (i_snoop_start && allow_q) begin
			busy_q <= 1'b1;
		end
	end

	assign lk.busy = busy_q;
	assign o_snoop_respond = busy_q;
endmodule : lps_snoop_link
`default_nettype wire

/* hdl/lps_vid_stepper.sv */
// lps_vid_stepper: walks the voltage-id code one code per dwell toward a
// target, or jumps in one move when asked.
// assumes target and jump inputs come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module lps_vid_stepper
	import lps_pkg::*;
#(
	parameter int STEP_CYC = VID_STEP_CYC
) (
	input wire logic i_clk, // core clock
	input wire logic i_sys_rst, // synchronous reset
	input wire logic [VID_W-1:0] i_target, // code to walk toward
	input wire logic i_jump, // load i_jump_code at once
	input wire logic [VID_W-1:0] i_jump_code, // code for a jump
	output logic [VID_W-1:0] o_vid, // current code
	output logic o_done // code equals target
);
	localparam int CW = $clog2(STEP_CYC + 1);
	logic [VID_W-1:0] vid_q;
	logic [CW-1:0] cnt_q;

	// refused at elaboration: a zero dwell would never let the counter idle
	if (STEP_CYC < 1) begin : g_bad_step
		$error("step dwell must be at least one cycle");
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			vid_q <= VID_RST;
			cnt_q <= '0;
		end else if (i_jump) begin
			vid_q <= i_jump_code;
			cnt_q <= CW'(STEP_CYC - 1);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else if (vid_q < i_target) begin
			vid_q <= vid_q + 1'b1;
			cnt_q <= CW'(STEP_CYC - 1);
		end else if (vid_q > i_target) begin
			vid_q <= vid_q - 1'b1;
			cnt_q <= CW'(STEP_CYC - 1);
		end
	end

	assign o_vid = vid_q;
	assign o_done = (vid_q == i_target);
endmodule : lps_vid_stepper
`default_nettype wire

/* dv/lps_fsb_model.sv */
// lps_fsb_model: chipset side of the bus: bus clock and snoop strobes.
// assumes the bench calls snoop_pulse only outside the sleep family.
`timescale 1ns/100ps
`default_nettype none
module lps_fsb_model (
	input wire logic i_deep_sleep_request_n, // deep sleep pin as driven
	output logic o_bclk, // bus clock, 32 ns period
	output logic o_snoop_start, // snoop begins
	output logic o_snoop_done // snoop serviced
);
	logic [1:0] stop_cnt_q;
	initial begin
		o_bclk = 1'b0;
		o_snoop_start = 1'b0;
		o_snoop_done = 1'b0;
		stop_cnt_q = 2'h0;
	end
	// the clock parks only after two edges with deep sleep asserted
	always @(posedge o_bclk or posedge i_deep_sleep_request_n) begin
		if (i_deep_sleep_request_n)
			stop_cnt_q <= 2'h0;
		else if (stop_cnt_q != 2'h2)
			stop_cnt_q <= stop_cnt_q + 2'h1;
	end
	// odd start offset keeps the edges apart from the core clock
	initial begin
		#3;
		forever begin
			#16;
			if (stop_cnt_q != 2'h2 || o_bclk)
				o_bclk = ~o_bclk;
		end
	end
	// never called while sleeping, so the bus stays quiet there
	task automatic snoop_pulse(input logic done);
		@(posedge o_bclk);
		if (done)
			o_snoop_done <= 1'b1;
		else
			o_snoop_start <= 1'b1;
		@(posedge o_bclk);
		o_snoop_start <= 1'b0;
		o_snoop_done <= 1'b0;
	endtask : snoop_pulse
endmodule : lps_fsb_model
`default_nettype wire

/* dv/tb_top.sv */
// tb_top: self-checking bench for the low-power sequencer.
// assumes lps_fsb_model supplies the bus clock and snoop strobes.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import lps_pkg::*;
	localparam int PLL = 20;
	localparam int HOLD = 4;
	localparam int STEP = 2;
	logic i_clk = 1'b0, i_sys_rst = 1'b1;
	logic halted = 1'b0, xh_en = 1'b0, xsg_en = 1'b0;
	logic stop_n = 1'b1, sleep_n = 1'b1, deep_n = 1'b1, deeper_n = 1'b1;
	logic brst_n = 1'b1, perf_wr = 1'b0;
	logic [VID_W-1:0] perf_vid = VID_RST, vid;
	logic [RATIO_W-1:0] perf_ratio = RATIO_RST, ratio;
	logic psi_n, tq_rdy, irq_en, clk_en, core_init, snp_rsp;
	logic bclk, snp_start, snp_done;
	logic [3:0] state;
	int fails = 0, checks_done = 0, init_cnt = 0;

	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) if (core_init === 1'b1) init_cnt++;

	lps_fsb_model lps_fsb_model_i (.i_deep_sleep_request_n(deep_n),
		.o_bclk(bclk), .o_snoop_start(snp_start), .o_snoop_done(snp_done));
	lps_sequencer #(.PLL_CYC(PLL), .HOLD_CYC(HOLD), .STEP_CYC(STEP))
	lps_sequencer_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bclk(bclk),
		.i_all_halted(halted), .i_ext_halt_en(xh_en),
		.i_ext_stopgrant_en(xsg_en), .i_stop_clock_request_n(stop_n),
		.i_sleep_request_n(sleep_n), .i_deep_sleep_request_n(deep_n),
		.i_deeper_voltage_request_n(deeper_n), .i_bus_reset_n(brst_n),
		.i_snoop_start(snp_start), .i_snoop_done(snp_done),
		.i_perf_wr(perf_wr), .i_perf_vid(perf_vid),
		.i_perf_ratio(perf_ratio), .o_voltage_id_code(vid),
		.o_core_ratio(ratio), .o_reduced_power_status_n(psi_n),
		.o_thermal_query_ready(tq_rdy), .o_irq_latch_en(irq_en),
		.o_core_clk_en(clk_en), .o_core_init(core_init),
		.o_snoop_respond(snp_rsp), .o_state(state));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	// v[7] set means any voltage code is accepted
	task automatic wait_for(input logic [3:0] st, input logic [7:0] v);
		for (int i = 0; i < 400; i++) begin
			@(posedge i_clk);
			#1;
			if (state === st && (v[7] || vid === v[6:0])) break;
		end
		check(state, st);
	endtask : wait_for

	task automatic count_until(input logic [3:0] st, output int n);
		logic bad;
		bad = 1'b0;
		for (n = 0; n < 400 && state !== st; n++) begin
			@(posedge i_clk);
			#1;
			if (state === ST_SG) bad = 1'b1;
		end
		check(bad, 1'b0);
	endtask : count_until

	task automatic perf(input logic [6:0] tv, input logic [4:0] tr,
		input logic [4:0] er);
		logic [6:0] pv, dv;
		logic [4:0] pr;
		logic up;
		up = er > ratio;
		pv = vid;
		pr = ratio;
		@(posedge i_clk);
		perf_wr <= 1'b1;
		perf_vid <= tv;
		perf_ratio <= tr;
		@(posedge i_clk);
		perf_wr <= 1'b0;
		for (int i = 0; i < 300; i++) begin
			@(posedge i_clk);
			#1;
			dv = vid - pv;
			if (vid !== pv) check(dv, up ? 7'h01 : 7'h7F);
			if (up && ratio !== pr) check(vid, tv);
			if (!up && vid !== pv) check(ratio, er);
			pv = vid;
			pr = ratio;
			if (vid === tv && ratio === er) break;
		end
		check({vid, ratio}, {tv, er});
	endtask : perf

	task automatic t_snoop();
		logic [3:0] idle_st [4] = '{ST_SG, ST_XSG, ST_HALT, ST_XHALT};
		logic [3:0] snp_st [4] = '{ST_SG_SNP, ST_XSG_SNP, ST_HALT_SNP,
			ST_XHALT_SNP};
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			xsg_en <= k[0];
			xh_en <= k[0];
			halted <= k[1];
			stop_n <= k[1];
			wait_for(idle_st[k], {1'b0, k[0] ? LOW_VID : VID_RST});
			lps_fsb_model_i.snoop_pulse(1'b0);
			@(posedge bclk);
			#1;
			check(snp_rsp, 1'b1);
			wait_for(snp_st[k], 8'h80);
			check({vid, ratio}, k[0] ? {LOW_VID, LOW_RATIO} :
				{VID_RST, RATIO_RST});
			lps_fsb_model_i.snoop_pulse(1'b1);
			wait_for(idle_st[k], 8'h80);
			check(snp_rsp, 1'b0);
			@(posedge i_clk);
			stop_n <= 1'b1;
			halted <= 1'b0;
			wait_for(ST_NORMAL, {1'b0, VID_RST});
		end
		$display("snoop test done");
	endtask : t_snoop

	task automatic to_sleep();
		@(posedge i_clk);
		xsg_en <= 1'b0;
		xh_en <= 1'b0;
		stop_n <= 1'b0;
		wait_for(ST_SG, 8'h80);
		@(posedge i_clk) sleep_n <= 1'b0;
		wait_for(ST_SLEEP, 8'h80);
		check({tq_rdy, irq_en, clk_en}, 3'h0);
	endtask : to_sleep

	task automatic t_sleep_chain();
		int n;
		to_sleep();
		@(posedge i_clk) deep_n <= 1'b0;
		wait_for(ST_DEEP, 8'h80);
		check({tq_rdy, irq_en, psi_n}, 3'h1);
		@(posedge i_clk) deeper_n <= 1'b0;
		wait_for(ST_DEEPER, 8'h80);
		repeat (2) @(posedge i_clk);
		#1;
		check(vid, VID_RST - DEEPER_DROP_CODES);
		check({psi_n, tq_rdy}, 2'h0);
		@(posedge i_clk) deeper_n <= 1'b1;
		wait_for(ST_DEEP, {1'b0, VID_RST});
		check(psi_n, 1'b1);
		@(posedge i_clk) deep_n <= 1'b1;
		wait_for(ST_PLL_WAIT, 8'h80);
		count_until(ST_SLEEP, n);
		check(n >= PLL && n <= PLL + 3, 1'b1);
		@(posedge i_clk) sleep_n <= 1'b1;
		wait_for(ST_SG, 8'h80);
		@(posedge i_clk) stop_n <= 1'b1;
		wait_for(ST_NORMAL, 8'h80);
		$display("sleep chain test done");
	endtask : t_sleep_chain

	task automatic t_reset_sleep();
		int n;
		to_sleep();
		init_cnt = 0;
		@(posedge i_clk) brst_n <= 1'b0;
		@(posedge i_clk);
		sleep_n <= 1'b1;
		stop_n <= 1'b1;
		count_until(ST_NORMAL, n);
		@(posedge i_clk);
		brst_n <= 1'b1;
		repeat (8) @(posedge i_clk);
		#1;
		check(n > HOLD && init_cnt == 1, 1'b1);
		check({state, vid, ratio}, {ST_NORMAL, VID_RST, RATIO_RST});
		$display("reset in sleep test done");
	endtask : t_reset_sleep

	task automatic complete_run();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	initial begin
		#400000;
		fails++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		check({state, vid, ratio}, {ST_NORMAL, VID_RST, RATIO_RST});
		check({psi_n, tq_rdy, irq_en, clk_en}, 4'hF);
		perf(7'h33, 5'h0B, 5'h0B);
		perf(7'h31, 5'h08, 5'h08);
		perf(7'h34, 5'h1F, MAX_RATIO);
		perf(VID_RST, RATIO_RST, RATIO_RST);
		$display("perf test done");
		t_snoop();
		t_sleep_chain();
		t_reset_sleep();
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
